// >>> hdl/tcu_defines.svh
// shared constants of the timer compare unit: mode codes and timer counts
`ifndef TCU_DEFINES_SVH
`define TCU_DEFINES_SVH

// compare mode select codes
`define TCU_MODE_OFF     4'h0
`define TCU_MODE_TOGGLE  4'h2
`define TCU_MODE_SET     4'h8
`define TCU_MODE_CLEAR   4'h9
`define TCU_MODE_SWINT   4'hA
`define TCU_MODE_SPECIAL 4'hB

// instruction clock is the system clock divided by this
`define TCU_INSN_DIV     3'h4

// timer count limits and reset values
`define TCU_COUNT_ZERO   16'h0000
`define TCU_COUNT_MAX    16'hFFFF
`define TCU_COUNT_STEP   16'h0001

`endif

// >>> hdl/tcu_pkg.sv
// types shared by the timer compare unit modules
package tcu_pkg;

  // action taken on a fresh match
  typedef enum logic [2:0]
  {
    act_none    = 3'b000,
    act_toggle  = 3'b001,
    act_set     = 3'b010,
    act_clear   = 3'b011,
    act_swint   = 3'b100,
    act_special = 3'b101
  } tcu_action_type;

  // state of one compare channel
  typedef struct packed
  {
    logic out;
    logic oe;
    logic flag;
    logic seen;
    logic adc;
  } tcu_chan_state_type;

  // state of the shared timer
  typedef struct packed
  {
    logic [15:0] count;
    logic [1:0]  div;
    logic [2:0]  sync;
    logic        ext_level;
    logic        ovf;
  } tcu_timer_state_type;

endpackage

// >>> hdl/tcu_channel.sv
// one compare channel: match detect, pin latch, flag and trigger
`timescale 1ns/100ps
`include "tcu_defines.svh"

module tcu_channel
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] timer_count,
  input  wire logic [7:0]  compare_value_high,
  input  wire logic [7:0]  compare_value_low,
  input  wire logic [3:0]  compare_mode_select,
  input  wire logic        adc_enable,
  input  wire logic        flag_clear,
  output logic             compare_out,
  output logic             compare_oe,
  output logic             compare_match_flag,
  output logic             special_event,
  output logic             adc_start_pulse
);
  import tcu_pkg::*;

  // ****************************************************************
  // mode decode
  // ****************************************************************
  // unlisted codes map to no action, so the channel stays idle
  function automatic tcu_pkg::tcu_action_type decode_mode
  (
    input logic [3:0] mode
  );
    case (mode)
      `TCU_MODE_TOGGLE:  decode_mode = act_toggle;
      `TCU_MODE_SET:     decode_mode = act_set;
      `TCU_MODE_CLEAR:   decode_mode = act_clear;
      `TCU_MODE_SWINT:   decode_mode = act_swint;
      `TCU_MODE_SPECIAL: decode_mode = act_special;
      default:           decode_mode = act_none;
    endcase
  endfunction

  tcu_chan_state_type state_reg;
  tcu_chan_state_type state_next;
  tcu_action_type     action;
  logic [15:0]        compare_value;
  logic               match;
  logic               fresh;

  // ****************************************************************
  // match detection
  // ****************************************************************
  // equality is checked every cycle; fresh marks the first cycle only
  assign compare_value = {compare_value_high, compare_value_low};
  assign match         = compare_value == timer_count;
  assign fresh         = match && !state_reg.seen;
  assign action        = decode_mode(compare_mode_select);

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    state_next      = state_reg;
    state_next.seen = match;
    // exactly one action per fresh match, flag raised on the same edge
    if (fresh)
    begin
      case (action)
        act_toggle: state_next.out = !state_reg.out;
        act_set:    state_next.out = 1'b1;
        act_clear:  state_next.out = 1'b0;
        default:    state_next.out = state_reg.out;
      endcase
    end
    // cleared control forces the latch low; port latch is elsewhere
    if (compare_mode_select == `TCU_MODE_OFF)
    begin
      state_next.out = 1'b0;
    end
    // pin driven only in pin modes; software must also set direction
    state_next.oe = (action == act_toggle) || (action == act_set)
                    || (action == act_clear);
    // set wins over a clear arriving in the same cycle
    if (fresh && action != act_none)
    begin
      state_next.flag = 1'b1;
    end
    else if (flag_clear)
    begin
      state_next.flag = 1'b0;
    end
    // one pulse per match, held off while the converter is disabled
    state_next.adc = fresh && action == act_special && adc_enable;
  end

  // state register
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign compare_out        = state_reg.out;
  assign compare_oe         = state_reg.oe;
  assign compare_match_flag = state_reg.flag;
  assign adc_start_pulse    = state_reg.adc;
  // trigger follows the match with no delay so the timer sees it early
  assign special_event      = match && action == act_special;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence fresh_s;
    match && !state_reg.seen;
  endsequence

  flag_same_a: assert property (fresh_s ##0 action != act_none
    |=> compare_match_flag) else $error("flag missed on match");
  set_out_a: assert property (fresh_s ##0 action == act_set
    |=> compare_out) else $error("set mode did not set");
  clear_out_a: assert property (fresh_s ##0 action == act_clear
    ##0 compare_mode_select != `TCU_MODE_OFF |=> !compare_out)
    else $error("clear mode did not clear");
  toggle_out_a: assert property (fresh_s ##0 action == act_toggle
    |=> compare_out != $past(compare_out))
    else $error("toggle mode did not toggle");
  swint_pin_a: assert property ((action == act_swint)[*2]
    |-> !compare_oe) else $error("pin driven in flag mode");
  off_low_a: assert property (compare_mode_select == `TCU_MODE_OFF
    |=> !compare_out) else $error("latch not low when off");
  adc_once_a: assert property (adc_start_pulse
    |-> $past(adc_enable) ##1 !adc_start_pulse)
    else $error("bad converter start pulse");

endmodule

// >>> hdl/tcu_top.sv
// timer compare unit: shared 16-bit timer with five compare channels
`timescale 1ns/100ps
`include "tcu_defines.svh"

module tcu_top
#(
  parameter int CHANNELS = 5
)
(
  input  wire logic                     sys_clk,
  input  wire logic                     rst_n,
  input  wire logic                     timer_enable,
  input  wire logic                     timer_ext_select,
  input  wire logic                     timer_ext_clk,
  input  wire logic                     overflow_flag_clear,
  input  wire logic                     adc_enable,
  input  wire logic [CHANNELS-1:0][7:0] compare_value_high,
  input  wire logic [CHANNELS-1:0][7:0] compare_value_low,
  input  wire logic [CHANNELS-1:0][3:0] compare_mode_select,
  input  wire logic [CHANNELS-1:0]      match_flag_clear,
  output logic      [7:0]               timer_count_high,
  output logic      [7:0]               timer_count_low,
  output logic                          timer_overflow_flag,
  output logic      [CHANNELS-1:0]      compare_output_pin,
  output logic      [CHANNELS-1:0]      compare_output_oe,
  output logic      [CHANNELS-1:0]      compare_match_flag,
  output logic      [CHANNELS-1:0]      special_event_trigger,
  output logic                          adc_start
);
  import tcu_pkg::*;

  localparam logic [1:0] DIV_LAST = 2'(`TCU_INSN_DIV - 3'h1);

  tcu_timer_state_type state_reg;
  tcu_timer_state_type state_next;
  logic [CHANNELS-1:0] adc_pulse;
  logic                ext_agree;
  logic                ext_rise;
  logic                insn_tick;
  logic                tick;
  logic                trigger_any;

  // ****************************************************************
  // timer clock selection
  // ****************************************************************
  // the external clock passes three flops; only the last two are
  // compared, so a change counts once it is seen twice in a row
  assign ext_agree = state_reg.sync[1] == state_reg.sync[2];
  assign ext_rise  = ext_agree && state_reg.sync[2]
                     && !state_reg.ext_level;

  // internal source is the instruction clock, never the raw clock
  assign insn_tick = state_reg.div == DIV_LAST;

  // one system cycle per timer clock edge
  assign tick = timer_enable
                && (timer_ext_select ? ext_rise : insn_tick);

  // any channel still matching in special mode at the timer edge
  assign trigger_any = |special_event_trigger;

  // ****************************************************************
  // timer next state
  // ****************************************************************
  always_comb
  begin
    state_next      = state_reg;
    state_next.sync = {state_reg.sync[1:0], timer_ext_clk};
    state_next.div  = 2'(state_reg.div + 2'h1);
    if (ext_agree)
    begin
      state_next.ext_level = state_reg.sync[2];
    end
    // overflow flag: hardware set wins over a software clear
    if (overflow_flag_clear)
    begin
      state_next.ovf = 1'b0;
    end
    if (tick)
    begin
      // trigger reset waits for the timer edge and only if the match
      // still holds, so a moved compare value cancels it
      if (trigger_any)
      begin
        state_next.count = `TCU_COUNT_ZERO;
      end
      else
      begin
        state_next.count = 16'(state_reg.count + `TCU_COUNT_STEP);
        // a trigger reset never reaches this branch
        if (state_reg.count == `TCU_COUNT_MAX)
        begin
          state_next.ovf = 1'b1;
        end
      end
    end
  end

  // timer state register
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign timer_count_high    = state_reg.count[15:8];
  assign timer_count_low     = state_reg.count[7:0];
  assign timer_overflow_flag = state_reg.ovf;

  // ****************************************************************
  // compare channels
  // ****************************************************************
  // every channel is the same logic with its own value, mode and flag
  generate
    for (genvar ch = 0; ch < CHANNELS; ch++)
    begin : g_chan
      tcu_channel u_chan
      (
        .sys_clk             (sys_clk),
        .rst_n               (rst_n),
        .timer_count         (state_reg.count),
        .compare_value_high  (compare_value_high[ch]),
        .compare_value_low   (compare_value_low[ch]),
        .compare_mode_select (compare_mode_select[ch]),
        .adc_enable          (adc_enable),
        .flag_clear          (match_flag_clear[ch]),
        .compare_out         (compare_output_pin[ch]),
        .compare_oe          (compare_output_oe[ch]),
        .compare_match_flag  (compare_match_flag[ch]),
        .special_event       (special_event_trigger[ch]),
        .adc_start_pulse     (adc_pulse[ch])
      );
    end
  endgenerate

  // converter start: channel pulses merged; each is already one cycle
  assign adc_start = |adc_pulse;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence trigger_edge_s;
    tick && trigger_any;
  endsequence

  sequence plain_edge_s;
    tick && !trigger_any;
  endsequence

  trig_reset_a: assert property (trigger_edge_s
    |=> state_reg.count == `TCU_COUNT_ZERO)
    else $error("trigger did not reset timer");

  trig_no_ovf_a: assert property (trigger_edge_s
    |=> !$rose(timer_overflow_flag))
    else $error("overflow set by trigger reset");

  no_match_count_a: assert property (plain_edge_s
    |=> state_reg.count == 16'($past(state_reg.count)
        + `TCU_COUNT_STEP))
    else $error("timer did not step without match");

  hold_count_a: assert property (!tick
    |=> state_reg.count == $past(state_reg.count))
    else $error("count moved between timer edges");

  insn_rate_a: assert property (tick && !timer_ext_select
    && timer_enable ##1 timer_enable && !timer_ext_select
    |-> !tick [*3])
    else $error("instruction tick faster than one in four");

  period_wrap_a: assert property (plain_edge_s ##0
    state_reg.count == `TCU_COUNT_MAX
    |=> timer_overflow_flag && state_reg.count == `TCU_COUNT_ZERO)
    else $error("overflow wrap wrong");

  pin_special_a: assert property (
    (compare_mode_select[0] == `TCU_MODE_SPECIAL) [*2]
    |-> !compare_output_oe[0])
    else $error("pin driven in trigger mode");

  adc_gate_a: assert property (!adc_enable |=> !adc_start)
    else $error("converter start while disabled");

  // a software clear only loses to a wrap landing in the same cycle
  ovf_clear_a: assert property (overflow_flag_clear
    && !(tick && !trigger_any && state_reg.count == `TCU_COUNT_MAX)
    |=> !timer_overflow_flag)
    else $error("overflow flag not cleared");

  // every channel keeps off its pin in trigger mode, not only the first
  for (genvar ch = 0; ch < CHANNELS; ch++)
  begin : g_pin_chk
    pin_each_a: assert property (
      (compare_mode_select[ch] == `TCU_MODE_SPECIAL) [*2]
      |-> !compare_output_oe[ch])
      else $error("pin driven in trigger mode");
  end

endmodule

// >>> bench/tcu_pin_model.sv
// board model of the compare pins: a pull-down on each pin
`timescale 1ns/100ps
// ****************************************
// pin model
// ****************************************
module tcu_pin_model
#(
  parameter int W = 5
)
(
  input  wire logic [W-1:0] drive_value,
  input  wire logic [W-1:0] drive_enable,
  output logic      [W-1:0] pin_level
);
  // a released pin sinks to the pull-down, never keeps the last value
  assign pin_level = drive_value & drive_enable;
endmodule

// >>> bench/tcu_top_tb_top.sv
// self-checking testbench of the timer compare unit
`timescale 1ns/100ps
`include "tcu_defines.svh"
module tcu_top_tb_top;
  // ****************************************
  // signals
  // ****************************************
  logic            sys_clk;
  logic            rst_n;
  logic            timer_enable;
  logic            ext_sel;
  logic            ext_clk;
  logic            adc_enable;
  logic            ovf_clr;
  logic [4:0][7:0] cv_high;
  logic [4:0][7:0] cv_low;
  logic [4:0][3:0] mode;
  logic [4:0]      flag_clr;
  logic [7:0]      cnt_high;
  logic [7:0]      cnt_low;
  logic            ovf;
  logic [4:0]      pin;
  logic [4:0]      oe;
  logic [4:0]      flag;
  logic [4:0]      trig;
  logic            adc_start;
  logic [4:0]      pin_level;
  logic [15:0]     v;
  logic            p;
  logic [3:0]      codes [7];
  int              bad_count;
  int              total_checks;
  int              seed;

  // 25 MHz system clock
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  tcu_top i_dut
  (
    .sys_clk               (sys_clk),
    .rst_n                 (rst_n),
    .timer_enable          (timer_enable),
    .timer_ext_select      (ext_sel),
    .timer_ext_clk         (ext_clk),
    .overflow_flag_clear   (ovf_clr),
    .adc_enable            (adc_enable),
    .compare_value_high    (cv_high),
    .compare_value_low     (cv_low),
    .compare_mode_select   (mode),
    .match_flag_clear      (flag_clr),
    .timer_count_high      (cnt_high),
    .timer_count_low       (cnt_low),
    .timer_overflow_flag   (ovf),
    .compare_output_pin    (pin),
    .compare_output_oe     (oe),
    .compare_match_flag    (flag),
    .special_event_trigger (trig),
    .adc_start             (adc_start)
  );

  tcu_pin_model i_pins
  (
    .drive_value  (pin),
    .drive_enable (oe),
    .pin_level    (pin_level)
  );

  // ****************************************
  // tasks and expectations
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic do_reset();
    rst_n = 1'b0;
    cyc(5);
    rst_n = 1'b1;
  endtask

  // bounded wait for the timer to reach a value
  task automatic wait_count(input logic [15:0] t);
    int n;
    n = 0;
    while ({cnt_high, cnt_low} !== t)
    begin
      cyc(1);
      n++;
      if (n > 3000)
      begin
        bad_count++;
        $display("Error at %0t: timer never reached %h", $time, t);
        final_report();
      end
    end
  endtask

  function automatic logic exp_pin(input logic [3:0] m, input logic q);
    case (m)
      `TCU_MODE_SET:    return 1'b1;
      `TCU_MODE_CLEAR:  return 1'b0;
      `TCU_MODE_OFF:    return 1'b0;
      `TCU_MODE_TOGGLE: return ~q;
      default:          return q;
    endcase
  endfunction

  function automatic logic drives(input logic [3:0] m);
    return m == `TCU_MODE_TOGGLE || m == `TCU_MODE_SET
           || m == `TCU_MODE_CLEAR;
  endfunction

  function automatic logic flags(input logic [3:0] m);
    return drives(m) || m == `TCU_MODE_SWINT
           || m == `TCU_MODE_SPECIAL;
  endfunction

  // one match in channel ch; q carries the expected pin latch
  task automatic step(input int ch, input logic [3:0] m,
                      input logic [15:0] t, inout logic q);
    logic sp;
    logic ae;
    sp = (m == `TCU_MODE_SPECIAL);
    ae = $random(seed);
    mode[ch] = m;
    {cv_high[ch], cv_low[ch]} = t;
    adc_enable = ae;
    ovf_clr = $random(seed);
    flag_clr[ch] = 1'b1;
    cyc(1);
    flag_clr[ch] = 1'b0;
    if (m == `TCU_MODE_OFF)
      q = 1'b0;
    wait_count(t);
    check(flag[ch], 1'b0);
    check(pin[ch], q);
    check(trig[ch], sp);
    cyc(1);
    q = exp_pin(m, q);
    check({flag[ch], oe[ch]}, {flags(m), drives(m)});
    check(pin[ch], q);
    check(pin_level[ch], drives(m) & q);
    check(flag & ~(5'h01 << ch), 16'h0000);
    check(adc_start, sp & ae);
    cyc(1);
    check(adc_start, 1'b0);
    if (sp)
    begin
      cyc(4);
      check({cnt_high, cnt_low}, 16'h0);
      check(ovf, 1'b0);
    end
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    seed = 36169;
    bad_count = 0;
    total_checks = 0;
    codes = '{`TCU_MODE_SET, `TCU_MODE_CLEAR, `TCU_MODE_TOGGLE,
              `TCU_MODE_SWINT, `TCU_MODE_SPECIAL, `TCU_MODE_OFF, 4'h5};
    rst_n = 1'b0;
    ovf_clr = 1'b0;
    timer_enable = 1'b1;
    ext_sel = 1'b0;
    ext_clk = 1'b0;
    adc_enable = 1'b0;
    cv_high = '0;
    cv_low = '0;
    mode = '0;
    flag_clr = '0;
    @(negedge sys_clk);
    do_reset();
    check({pin, oe, flag}, 16'h0);
    // every code in every channel, followed by a random second code
    for (int ch = 0; ch < 5; ch++)
      for (int k = 0; k < 7; k++)
      begin
        mode = '0;
        do_reset();
        p = 1'b0;
        v = 16'(2 + $unsigned($random(seed)) % 20);
        step(ch, codes[k], v, p);
        step(ch, codes[$unsigned($random(seed)) % 7], v + 16'h0003, p);
      end
    // match removed before the timer clock: no timer reset
    mode = '0;
    do_reset();
    mode[4] = `TCU_MODE_SPECIAL;
    {cv_high[4], cv_low[4]} = 16'h0009;
    wait_count(16'h0009);
    {cv_high[4], cv_low[4]} = 16'h000B;
    cyc(5);
    check({cnt_high, cnt_low}, 16'h000A);
    // external clock pulses, wide enough for the synchroniser
    mode = '0;
    do_reset();
    ext_sel = 1'b1;
    for (int i = 0; i < 9; i++)
    begin
      if (i == 6)
        timer_enable = 1'b0;
      ext_clk = 1'b1;
      cyc(3);
      ext_clk = 1'b0;
      cyc(3);
    end
    cyc(5);
    check({cnt_high, cnt_low}, 16'h0006);
    check(ovf, 1'b0);
    final_report();
  end
endmodule
